// >>> logic/pbc_base_clock.sv
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Behaviour
// RULE1: upper nibble of loop programming holds feedback multiplier N.
// RULE2: lower nibble holds VCO linear range multiplier L.
// RULE3: multiplier zero drives the feedback divider as one.
// RULE4: range zero disables the loop and blocks VCO selection.
// RULE5: range zero forces the crystal clock as base source.
// RULE6: a switch waits three crystal and three VCO edges.
// RULE7: base clock output holds still during a switch.
// RULE8: selected clock is divided by two for a 50% duty output.
// RULE9: the select bit picks crystal or VCO as base source.
// RULE10: select one routes VCO over two, zero routes crystal over two.
// RULE11: select cannot be set while the loop is off.
// RULE12: loop-on cannot be cleared while VCO is selected.
// RULE13: loop on/off and select change need separate writes.
// RULE14: reset and stop clear select; reset sets loop-on.
// RULE15: both fields ignore writes while loop on; reset to six.
// RULE16: oscillator enable gates both the oscillator and the loop.
// RULE17: lock detector drives the interrupt request output.
// RULE18: software derives N from VCO over crystal frequency.
// RULE19: software derives L from VCO over the nominal center.
// RULE20: switch gates old source off before new one, synchronised.
module pbc_base_clock (
  // system
  input wire logic clk,
  input wire logic rst_b,
  // axi4-lite write address
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // axi4-lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // axi4-lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read address
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // axi4-lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // clock sources and system inputs
  input wire logic crystal_clock,
  input wire logic vco_clock,
  input wire logic osc_enable_in,
  input wire logic stop_in,
  input wire logic lock_detect_in,
  // outputs
  output logic base_clock_out,
  output logic osc_active,
  output logic loop_active,
  output logic [3:0] feedback_divisor,
  output logic [3:0] vco_range_select,
  output logic lock_irq
);
  // byte address of a register index
  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx[5:0], 2'b00};
  endfunction : reg_addr

  // decode: 0 ctrl, 1 prog, 2 stat, 3 unmapped
  function automatic logic [1:0] decode(input logic [7:0] a);
    if (a == reg_addr(pbc_pkg::IDX_CTRL)) begin
      decode = 2'd0;
    end else if (a == reg_addr(pbc_pkg::IDX_PROG)) begin
      decode = 2'd1;
    end else if (a == reg_addr(pbc_pkg::IDX_STAT)) begin
      decode = 2'd2;
    end else begin
      decode = 2'd3;
    end
  endfunction : decode

  logic aw_hold_r;
  logic [7:0] awaddr_r;
  logic w_hold_r;
  logic [7:0] wbyte_r;
  logic wlane_r;
  logic wr_fire;
  logic [1:0] wr_sel;
  logic rd_fire;
  logic [1:0] rd_sel;
  logic ctrl_rd;
  logic ctrl_wr;
  logic prog_wr;

  logic ie_r;
  logic flag_r;
  logic on_r;
  logic sel_r;
  logic [7:0] prog_r;
  logic lock_prev_r;
  logic lock_toggle;

  logic [3:0] mul;
  logic [3:0] rng;
  logic rng_zero;
  logic on_nxt;
  logic sel_nxt;
  logic [7:0] ctrl_val;
  logic [7:0] stat_val;
  logic [7:0] rd_val;
  pbc_pkg::pbc_sw_stat_s sw_stat;

  // ---- write channels, taken in either order
  assign s_awready = ~aw_hold_r & ~s_bvalid;
  assign s_wready = ~w_hold_r & ~s_bvalid;
  assign wr_fire = aw_hold_r & w_hold_r & ~s_bvalid;
  assign wr_sel = decode(awaddr_r);
  // a register write lands only with byte lane 0 strobed
  assign ctrl_wr = wr_fire & wlane_r & (wr_sel == 2'd0);
  assign prog_wr = wr_fire & wlane_r & (wr_sel == 2'd1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_awvalid && s_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= s_awaddr;
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_hold_r <= 1'b0;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
    end else if (s_wvalid && s_wready) begin
      w_hold_r <= 1'b1;
      wbyte_r <= s_wdata[7:0];
      wlane_r <= s_wstrb[0];
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_bvalid <= 1'b1;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // unmapped offsets answer with an error and change nothing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_bresp <= pbc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_bresp <= (wr_sel == 2'd3) ? pbc_pkg::RESP_SLVERR
                                  : pbc_pkg::RESP_OKAY;
    end
  end

  // ---- read channel
  assign s_arready = ~s_rvalid;
  assign rd_fire = s_arvalid & s_arready;
  assign rd_sel = decode(s_araddr);
  assign ctrl_rd = rd_fire & (rd_sel == 2'd0);

  always_comb begin
    ctrl_val = {ie_r, flag_r, on_r, sel_r, pbc_pkg::CTRL_UNUSED};
    stat_val = 8'h00;
    stat_val[pbc_pkg::STAT_BUSY_BIT] = sw_stat.busy;
    stat_val[pbc_pkg::STAT_VCO_BIT] = sw_stat.on_vco;
    stat_val[pbc_pkg::STAT_LOOP_BIT] = loop_active;
    stat_val[pbc_pkg::STAT_OSC_BIT] = osc_active;
    if (rd_sel == 2'd0) begin
      rd_val = ctrl_val;
    end else if (rd_sel == 2'd1) begin
      rd_val = prog_r;
    end else if (rd_sel == 2'd2) begin
      rd_val = stat_val;
    end else begin
      rd_val = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_rvalid <= 1'b0;
    end else if (rd_fire) begin
      s_rvalid <= 1'b1;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // data held until the next accepted address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_rdata <= 32'h0000_0000;
      s_rresp <= pbc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_rdata <= {24'h00_0000, rd_val};
      s_rresp <= (rd_sel == 2'd3) ? pbc_pkg::RESP_SLVERR
                                  : pbc_pkg::RESP_OKAY;
    end
  end

  // ---- programming fields
  assign mul = prog_r[pbc_pkg::PROG_MUL_HI:pbc_pkg::PROG_MUL_LO]; // [RULE1]
  assign rng = prog_r[pbc_pkg::PROG_RNG_HI:pbc_pkg::PROG_RNG_LO]; // [RULE2]
  assign rng_zero = (rng == 4'h0);

  // fields locked while the loop runs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_r <= pbc_pkg::PROG_RST; // [RULE15]
    end else if (prog_wr && !on_r) begin
      prog_r <= wbyte_r; // [RULE15]
    end
  end

  // ---- control interlocks
  always_comb begin
    on_nxt = wbyte_r[pbc_pkg::CTRL_ON_BIT];
    sel_nxt = wbyte_r[pbc_pkg::CTRL_SEL_BIT];
    // no clearing the loop while the VCO drives the output
    if (sel_r && !on_nxt) begin
      on_nxt = 1'b1; // [RULE12]
    end
    // select may only move when the loop bit stays put
    if (on_nxt != on_r) begin
      sel_nxt = sel_r; // [RULE13]
    end
    // no VCO selection while the loop is off or range zero
    if (sel_nxt && (!on_r || rng_zero)) begin
      sel_nxt = 1'b0; // [RULE11] [RULE4]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      on_r <= pbc_pkg::CTRL_ON_RST; // [RULE14]
    end else if (ctrl_wr) begin
      on_r <= on_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_r <= pbc_pkg::CTRL_SEL_RST; // [RULE14]
    end else if (stop_in) begin
      sel_r <= 1'b0; // [RULE14]
    end else if (rng_zero) begin
      sel_r <= 1'b0; // [RULE5]
    end else if (ctrl_wr) begin
      sel_r <= sel_nxt; // [RULE9]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ie_r <= pbc_pkg::CTRL_IE_RST;
    end else if (ctrl_wr) begin
      ie_r <= wbyte_r[pbc_pkg::CTRL_IE_BIT];
    end
  end

  // ---- lock change flag; a change beats the clearing read
  assign lock_toggle = (lock_detect_in ^ lock_prev_r) & loop_active;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_prev_r <= 1'b0;
    end else begin
      lock_prev_r <= lock_detect_in;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
    end else if (lock_toggle) begin
      flag_r <= 1'b1; // [RULE17]
    end else if (ctrl_rd) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_irq <= 1'b0;
    end else begin
      lock_irq <= (flag_r | lock_toggle) & ie_r & ~ctrl_rd; // [RULE17]
    end
  end

  // ---- analog controls
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_active <= 1'b0;
    end else begin
      osc_active <= osc_enable_in; // [RULE16]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_active <= 1'b0;
    end else begin
      loop_active <= osc_enable_in & on_r & ~rng_zero; // [RULE16] [RULE4]
    end
  end

  // a zero multiplier would stall the divider, so it runs as one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      feedback_divisor <= 4'h1;
    end else begin
      feedback_divisor <= (mul == 4'h0) ? 4'h1 : mul; // [RULE3]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vco_range_select <= 4'h0;
    end else begin
      vco_range_select <= rng; // [RULE2]
    end
  end

  // ---- base clock switch
  pbc_clock_switch u_switch (
    .clk(clk),
    .rst_b(rst_b),
    .crystal_clock(crystal_clock),
    .vco_clock(vco_clock),
    .xtal_en(osc_active),
    .vco_en(loop_active),
    .want_vco(sel_r), // [RULE10]
    .base_clock_out(base_clock_out),
    .stat(sw_stat)
  );
endmodule : pbc_base_clock

// >>> logic/pbc_pkg.sv
package pbc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h1C;
  localparam logic [7:0] IDX_PROG = 8'h1E;
  localparam logic [7:0] IDX_STAT = 8'h1F;
  localparam int unsigned ADDR_W = 8;

  // loop control register fields
  localparam int unsigned CTRL_IE_BIT = 7;
  localparam int unsigned CTRL_FLAG_BIT = 6;
  localparam int unsigned CTRL_ON_BIT = 5;
  localparam int unsigned CTRL_SEL_BIT = 4;
  localparam logic [3:0] CTRL_UNUSED = 4'hF;

  // loop programming register fields
  localparam int unsigned PROG_MUL_HI = 7;
  localparam int unsigned PROG_MUL_LO = 4;
  localparam int unsigned PROG_RNG_HI = 3;
  localparam int unsigned PROG_RNG_LO = 0;

  // status register fields
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_VCO_BIT = 1;
  localparam int unsigned STAT_LOOP_BIT = 2;
  localparam int unsigned STAT_OSC_BIT = 3;

  // values after reset
  localparam logic [7:0] PROG_RST = 8'h66;
  localparam logic CTRL_ON_RST = 1'b1;
  localparam logic CTRL_SEL_RST = 1'b0;
  localparam logic CTRL_IE_RST = 1'b0;

  // source clock edges to wait during a switch
  localparam logic [1:0] EDGE_WAIT = 2'h3;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PBC_SW_RUN = 2'b00,
    PBC_SW_GATE_OFF = 2'b01,
    PBC_SW_WAIT = 2'b10
  } pbc_sw_state_e;

  typedef struct packed {
    logic busy;
    logic on_vco;
  } pbc_sw_stat_s;
endpackage : pbc_pkg

// >>> logic/pbc_clock_switch.sv
`timescale 1ns/1ps
module pbc_clock_switch (
  // system
  input wire logic clk,
  input wire logic rst_b,
  // source clocks, sampled on clk
  input wire logic crystal_clock,
  input wire logic vco_clock,
  input wire logic xtal_en,
  input wire logic vco_en,
  // selection
  input wire logic want_vco,
  // result
  output logic base_clock_out,
  output pbc_pkg::pbc_sw_stat_s stat
);
  logic [2:0] xs_r;
  logic [2:0] vs_r;
  logic rise_x;
  logic rise_v;
  logic fall_old;
  logic old_en;
  logic done_x;
  logic done_v;
  logic cur_vco_r;
  logic [1:0] cnt_x_r;
  logic [1:0] cnt_v_r;
  pbc_pkg::pbc_sw_state_e state_r;

  // two-flop synchronisers, third stage for edges [RULE20]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xs_r <= 3'h0;
      vs_r <= 3'h0;
    end else begin
      xs_r <= {xs_r[1:0], crystal_clock & xtal_en};
      vs_r <= {vs_r[1:0], vco_clock & vco_en};
    end
  end

  assign rise_x = xs_r[1] & ~xs_r[2];
  assign rise_v = vs_r[1] & ~vs_r[2];
  assign old_en = cur_vco_r ? vco_en : xtal_en;
  assign fall_old = cur_vco_r ? (~vs_r[1] & vs_r[2])
                              : (~xs_r[1] & xs_r[2]);
  assign done_x = (cnt_x_r == pbc_pkg::EDGE_WAIT) | ~xtal_en;
  assign done_v = (cnt_v_r == pbc_pkg::EDGE_WAIT) | ~vco_en;

  // old source gated off on its falling edge, then both counted [RULE6]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= pbc_pkg::PBC_SW_RUN;
      cur_vco_r <= 1'b0;
      cnt_x_r <= 2'h0;
      cnt_v_r <= 2'h0;
    end else begin
      case (state_r)
        pbc_pkg::PBC_SW_RUN: begin
          if (want_vco != cur_vco_r) begin
            state_r <= pbc_pkg::PBC_SW_GATE_OFF;
          end
        end
        pbc_pkg::PBC_SW_GATE_OFF: begin
          if (fall_old || !old_en) begin // [RULE20]
            state_r <= pbc_pkg::PBC_SW_WAIT;
            cnt_x_r <= 2'h0;
            cnt_v_r <= 2'h0;
          end
        end
        pbc_pkg::PBC_SW_WAIT: begin
          if (rise_x && !done_x) begin
            cnt_x_r <= cnt_x_r + 2'h1;
          end
          if (rise_v && !done_v) begin
            cnt_v_r <= cnt_v_r + 2'h1;
          end
          if (done_x && done_v) begin
            cur_vco_r <= want_vco; // [RULE10]
            state_r <= pbc_pkg::PBC_SW_RUN;
          end
        end
        default: begin
          state_r <= pbc_pkg::PBC_SW_RUN;
        end
      endcase
    end
  end

  // divide by two, held still while switching [RULE7] [RULE8]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_clock_out <= 1'b0;
    end else if (state_r == pbc_pkg::PBC_SW_RUN &&
                 (cur_vco_r ? rise_v : rise_x)) begin
      base_clock_out <= ~base_clock_out;
    end
  end

  assign stat.busy = (state_r != pbc_pkg::PBC_SW_RUN);
  assign stat.on_vco = cur_vco_r;
endmodule : pbc_clock_switch

// >>> verification/pbc_base_clock_assertions.sv
`timescale 1ns/1ps
module pbc_base_clock_assertions (
  // system
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // clock control
  input wire logic osc_enable_in,
  input wire logic base_clock_out,
  input wire logic osc_active,
  input wire logic loop_active,
  input wire logic [3:0] feedback_divisor,
  input wire logic [3:0] vco_range_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence out_held;
    $stable(base_clock_out) [*3];
  endsequence
  a_div_nonzero: assert property (feedback_divisor != 4'h0)
    else $error("feedback divisor reads zero");
  a_osc_gated: assert property (!osc_enable_in |=> !osc_active)
    else $error("oscillator active while disabled");
  a_loop_gated: assert property (!osc_enable_in |=> !loop_active)
    else $error("loop active while oscillator disabled");
  a_loop_range: assert property (
    loop_active |-> vco_range_select != 4'h0)
    else $error("loop active with range zero");
  a_base_spacing: assert property (
    $changed(base_clock_out) |=> out_held)
    else $error("base clock toggled too soon");
  a_b_release: assert property ($fell(s_bvalid) |-> $past(s_bready))
    else $error("write response dropped unaccepted");
  a_r_release: assert property ($fell(s_rvalid) |-> $past(s_rready))
    else $error("read data dropped unaccepted");
  a_read_answer: assert property (
    s_arvalid && s_arready |=> s_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (wr_taken |-> ##[1:2] s_bvalid)
    else $error("write not answered in time");
  a_ar_refused: assert property (s_rvalid |-> !s_arready)
    else $error("read address taken while data pending");
endmodule : pbc_base_clock_assertions
bind pbc_base_clock pbc_base_clock_assertions u_pbc_base_clock_assertions (
  .clk(clk),
  .rst_b(rst_b),
  .s_awvalid(s_awvalid),
  .s_awready(s_awready),
  .s_wvalid(s_wvalid),
  .s_wready(s_wready),
  .s_bvalid(s_bvalid),
  .s_bready(s_bready),
  .s_arvalid(s_arvalid),
  .s_arready(s_arready),
  .s_rvalid(s_rvalid),
  .s_rready(s_rready),
  .osc_enable_in(osc_enable_in),
  .base_clock_out(base_clock_out),
  .osc_active(osc_active),
  .loop_active(loop_active),
  .feedback_divisor(feedback_divisor),
  .vco_range_select(vco_range_select)
);

// >>> verification/pbc_base_clock_test.sv
`timescale 1ns/1ps
module pbc_base_clock_test;
  localparam logic [7:0] A_CTRL = pbc_pkg::IDX_CTRL << 2;
  localparam logic [7:0] A_PROG = pbc_pkg::IDX_PROG << 2;
  localparam logic [7:0] A_STAT = pbc_pkg::IDX_STAT << 2;
  logic clk, rst_b, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, lock_irq;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb, feedback_divisor, vco_range_select;
  logic [1:0] s_bresp, s_rresp;
  logic crystal_clock, vco_clock, osc_enable_in, stop_in, lock_detect_in;
  logic base_clock_out, osc_active, loop_active;
  int n_fail, checks_done;

  pbc_base_clock u_pbc_base_clock (
    .clk(clk),
    .rst_b(rst_b),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .crystal_clock(crystal_clock),
    .vco_clock(vco_clock),
    .osc_enable_in(osc_enable_in),
    .stop_in(stop_in),
    .lock_detect_in(lock_detect_in),
    .base_clock_out(base_clock_out),
    .osc_active(osc_active),
    .loop_active(loop_active),
    .feedback_divisor(feedback_divisor),
    .vco_range_select(vco_range_select),
    .lock_irq(lock_irq)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // source clocks run free at 10 and 14 clk periods, edges on clk falling edges
  initial begin
    crystal_clock = 1'b0;
    forever #100 crystal_clock = ~crystal_clock;
  end
  initial begin
    vco_clock = 1'b0;
    forever #140 vco_clock = ~vco_clock;
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    s_awaddr <= a;
    s_wdata <= {24'h00_0000, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    chk("bresp", s_bresp, er);
    s_bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, e, input logic [1:0] er);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    chk("rdata", s_rdata, {24'h00_0000, e});
    chk("rresp", s_rresp, er);
    s_rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic period(input int p);
    time t0;
    time t1;
    @(posedge base_clock_out);
    t0 = $time;
    @(negedge base_clock_out);
    t1 = $time;
    chk("high_ns", 32'(t1 - t0), p / 2);
    @(posedge base_clock_out);
    chk("period_ns", 32'($time - t0), p);
  endtask : period

  task automatic t_reset;
    rd(A_CTRL, 8'h2F, pbc_pkg::RESP_OKAY);
    rd(A_PROG, pbc_pkg::PROG_RST, pbc_pkg::RESP_OKAY);
    chk("divisor", feedback_divisor, 4'h6);
    chk("range", vco_range_select, 4'h6);
    wr(A_PROG, 8'h00, pbc_pkg::RESP_OKAY);
    rd(A_PROG, 8'h66, pbc_pkg::RESP_OKAY);
    $display("test reset done");
  endtask : t_reset

  task automatic t_fields;
    wr(A_CTRL, 8'h00, pbc_pkg::RESP_OKAY);
    rd(A_CTRL, 8'h0F, pbc_pkg::RESP_OKAY);
    wr(A_PROG, 8'h05, pbc_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("divisor", feedback_divisor, 4'h1);
    chk("range", vco_range_select, 4'h5);
    wr(A_PROG, 8'hA7, pbc_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("divisor", feedback_divisor, 4'hA);
    chk("range", vco_range_select, 4'h7);
    $display("test fields done");
  endtask : t_fields

  task automatic t_interlock;
    wr(A_CTRL, 8'h10, pbc_pkg::RESP_OKAY);
    rd(A_CTRL, 8'h0F, pbc_pkg::RESP_OKAY);
    wr(A_CTRL, 8'h30, pbc_pkg::RESP_OKAY);
    rd(A_CTRL, 8'h2F, pbc_pkg::RESP_OKAY);
    wr(A_CTRL, 8'h30, pbc_pkg::RESP_OKAY);
    rd(A_CTRL, 8'h3F, pbc_pkg::RESP_OKAY);
    wr(A_CTRL, 8'h10, pbc_pkg::RESP_OKAY);
    rd(A_CTRL, 8'h3F, pbc_pkg::RESP_OKAY);
    $display("test interlock done");
  endtask : t_interlock

  task automatic t_switch;
    repeat (150) @(posedge clk);
    period(560);
    rd(A_STAT, 8'h0E, pbc_pkg::RESP_OKAY);
    @(posedge clk);
    stop_in <= 1'b1;
    @(posedge clk);
    stop_in <= 1'b0;
    rd(A_CTRL, 8'h2F, pbc_pkg::RESP_OKAY);
    repeat (150) @(posedge clk);
    period(400);
    rd(A_STAT, 8'h0C, pbc_pkg::RESP_OKAY);
    $display("test switch done");
  endtask : t_switch

  task automatic t_irq;
    wr(A_CTRL, 8'hA0, pbc_pkg::RESP_OKAY);
    @(posedge clk);
    lock_detect_in <= 1'b1;
    repeat (6) @(posedge clk);
    chk("loop_active", loop_active, 1'b1);
    chk("lock_irq", lock_irq, 1'b1);
    rd(A_CTRL, 8'hEF, pbc_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("lock_irq", lock_irq, 1'b0);
    $display("test irq done");
  endtask : t_irq

  task automatic t_range_zero;
    wr(A_CTRL, 8'h00, pbc_pkg::RESP_OKAY);
    wr(A_PROG, 8'h70, pbc_pkg::RESP_OKAY);
    wr(A_CTRL, 8'h20, pbc_pkg::RESP_OKAY);
    wr(A_CTRL, 8'h30, pbc_pkg::RESP_OKAY);
    rd(A_CTRL, 8'h2F, pbc_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("loop_active", loop_active, 1'b0);
    wr(8'h00, 8'h55, pbc_pkg::RESP_SLVERR);
    rd(8'h00, 8'h00, pbc_pkg::RESP_SLVERR);
    @(posedge clk);
    osc_enable_in <= 1'b0;
    repeat (3) @(posedge clk);
    chk("osc_active", osc_active, 1'b0);
    $display("test range zero done");
  endtask : t_range_zero

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    #200us;
    n_fail++;
    final_report();
  end

  initial begin
    n_fail = 0;
    checks_done = 0;
    rst_b = 1'b0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'h1;
    osc_enable_in = 1'b1;
    stop_in = 1'b0;
    lock_detect_in = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_fields();
    t_interlock();
    t_switch();
    t_irq();
    t_range_zero();
    final_report();
  end
endmodule : pbc_base_clock_test
